// ===== bench/sscd_properties.sv
// concurrent checks on the serial command link and the device's static outputs
`timescale 1ns/1ps
`default_nettype none
module sscd_properties (
  input wire logic                          core_clk,
  input wire logic                          nrst,
  input wire logic                          hostSelectN,
  input wire logic                          hostSclk,
  input wire logic                          hostMosi,
  input wire logic                          hostMiso,
  input wire logic [sscd_pkg::SUB_COUNT-1:0] subSelectN,
  input wire logic                          synth_core_commit_pulse,
  input wire logic [2:0]                    dividerLines,
  input wire logic [5:0]                    gainLines
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_open;
    $fell(hostSelectN);
  endsequence
  sequence s_held;
    !hostSelectN [*8];
  endsequence
  sequence s_sclk_high;
    hostSclk [*4] ##1 !hostSclk;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_FRAME_HELD: assert property (s_open |=> s_held)
    else $error("host select released inside a byte");
  AST_SCLK_HALF: assert property ($rose(hostSclk) |-> s_sclk_high)
    else $error("link clock high phase not four cycles");
  AST_SCLK_IDLE: assert property (hostSelectN [*2] |-> !hostSclk)
    else $error("link clock moving outside a frame");
  // selects go through a synchroniser, so allow eight cycles before demanding release
  AST_SUB_RELEASE: assert property (hostSelectN [*8] |-> &subSelectN)
    else $error("sub-device select held after frame end");
  AST_SUB_ONE: assert property ($onehot0(~subSelectN))
    else $error("two sub-device selects active");
  AST_SUB_IN_FRAME: assert property ($fell(&subSelectN) |-> !hostSelectN)
    else $error("sub-device selected outside a frame");
  AST_COMMIT_ONE: assert property (synth_core_commit_pulse |=> !synth_core_commit_pulse)
    else $error("commit pulse longer than one cycle");
  AST_COMMIT_FRAME: assert property (synth_core_commit_pulse |-> !hostSelectN)
    else $error("commit pulse outside a frame");
  AST_DIV_HOLD: assert property (!$stable(dividerLines) |-> !hostSelectN)
    else $error("divider lines changed outside a command");
  AST_GAIN_HOLD: assert property (!$stable(gainLines) |-> !hostSelectN)
    else $error("gain lines changed outside a command");
  // the device samples data on the rising link clock, so data may only move while it is low
  AST_MOSI_STABLE: assert property (hostSclk && $past(hostSclk) |-> $stable(hostMosi))
    else $error("host data changed while link clock high");
  AST_MISO_IDLE: assert property (hostSelectN [*8] |-> !hostMiso)
    else $error("device reply line active outside a frame");
endmodule
`default_nettype wire

// ===== bench/synth_spi_command_decoder_test.sv
// self-checking bench: host end driven over APB, device end on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module synth_spi_command_decoder_test;
  logic                           core_clk, nrst, pllLock, psel, penable, pwrite;
  logic                           pready, pslverr, auxPin, commitPulse, subSclk, subMosi;
  logic                           clrMon, markSeen, relaySeen;
  logic [7:0]                     paddr, rxByte, funcLines, commitCnt;
  logic [31:0]                    pwdata, prdata, scratch;
  logic [2:0]                     dividerLines;
  logic [5:0]                     gainLines;
  logic [sscd_pkg::SUB_COUNT-1:0] subSelectN, subMiso, selSeen;
  logic [7:0]                     linkCmd [5];
  int                             linkLen [5];
  int                             badCount, nCompared;
  logic                           expPin;

  sscd_link_if link ();
  sscd_device sscd_device_inst (.core_clk(core_clk), .nrst(nrst), .link(link.device),
    .pllLock(pllLock), .aux_monitor_pin(auxPin), .synth_core_commit_pulse(commitPulse),
    .funcLines(funcLines), .dividerLines(dividerLines), .gainLines(gainLines),
    .subSelectN(subSelectN), .subSclk(subSclk), .subMosi(subMosi), .subMiso(subMiso));
  sscd_host sscd_host_inst (.core_clk(core_clk), .nrst(nrst), .link(link.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  sscd_properties sscd_properties_inst (.core_clk(core_clk), .nrst(nrst),
    .hostSelectN(link.hostSelectN), .hostSclk(link.hostSclk), .hostMosi(link.hostMosi),
    .hostMiso(link.hostMiso), .subSelectN(subSelectN), .synth_core_commit_pulse(commitPulse),
    .dividerLines(dividerLines), .gainLines(gainLines));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // activity seen during a frame is accumulated, since the bench only looks after it ends
  always @(posedge core_clk) begin
    if (clrMon) begin
      selSeen <= '0;
      markSeen <= 1'b0;
      relaySeen <= 1'b0;
      commitCnt <= 8'h00;
    end else begin
      selSeen <= selSeen | ~subSelectN;
      markSeen <= markSeen | auxPin;
      relaySeen <= relaySeen | (subSclk & subMosi);
      commitCnt <= commitCnt + {7'h00, commitPulse};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task printVerdict;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task hang(input string what);
    badCount++;
    $display("BAD %s expected done seen timeout", what);
    printVerdict();
  endtask

  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 64);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 64) hang("pready");
  endtask

  // one whole frame: command, n data bytes each equal to d; the last received byte lands in rxByte
  task send(input logic [7:0] cmd, input logic [7:0] n, input logic [7:0] d);
    int i;
    apb(1'b1, sscd_pkg::APB_CTRL, {d, 7'h00, 1'b1, n, cmd}, scratch);
    i = 0;
    do begin
      apb(1'b0, sscd_pkg::APB_STAT, 32'h0, scratch);
      i++;
    end while (scratch[0] !== 1'b0 && i < 500);
    if (i >= 500) hang("busy");
    apb(1'b0, sscd_pkg::APB_RDATA, 32'h0, scratch);
    rxByte = scratch[7:0];
  endtask

  task clr;
    clrMon <= 1'b1;
    @(posedge core_clk);
    clrMon <= 1'b0;
  endtask

  task markCase(input logic [7:0] aux, input logic [7:0] cmd, input logic [7:0] d,
                input logic exp);
    logic expCommit;
    expCommit = (cmd == sscd_pkg::CMD_COMMIT) || (cmd == sscd_pkg::CMD_ALL_UPD);
    send(sscd_pkg::CMD_AUX_WR, 8'h01, aux);
    clr();
    send(cmd, 8'h01, d);
    check("marker", exp, markSeen);
    check("marker_after_frame", 0, auxPin);
    check("commit", expCommit, commitCnt);
    check("no_relay", 0, relaySeen);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pllLock = 1'b0;
    subMiso = 5'h0A;
    clrMon = 1'b1;
    badCount = 0;
    nCompared = 0;
    linkCmd = '{sscd_pkg::CMD_CORE_LINK, sscd_pkg::CMD_TEMP_LINK, sscd_pkg::CMD_ADC_LINK,
                sscd_pkg::CMD_POT_LINK, sscd_pkg::CMD_FLASH_LINK};
    linkLen = '{3, 2, 2, 3, 2};
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    clrMon <= 1'b0;
    check("sub_sel_reset", 5'h1F, subSelectN);
    check("aux_pin_reset", 0, auxPin);
    send(sscd_pkg::CMD_AUX_RD, 8'h01, 8'h00);
    check("aux_reset", 8'h00, rxByte);
    $display("test reset done");

    for (int k = 0; k < 8; k++) begin
      pllLock <= k[2];
      send(sscd_pkg::CMD_AUX_WR, 8'h01, {6'h00, k[1:0]});
      send(sscd_pkg::CMD_AUX_RD, 8'h01, 8'h00);
      check("aux_reg", {6'h00, k[1:0]}, rxByte);
      expPin = (k[1:0] == 2'h3) || (k[1:0] == 2'h1 && k[2]);
      check("aux_pin", expPin, auxPin);
    end
    $display("test aux sources done");

    send(sscd_pkg::CMD_DIV_WR, 8'h01, 8'h05);
    check("div_buffered", 3'h0, dividerLines);
    send(8'h82, 8'h01, 8'h00);
    check("div_buffer_read", 8'h05, rxByte);
    send(sscd_pkg::CMD_DIV_UPD, 8'h01, 8'h00);
    check("div_updated", 3'h5, dividerLines);
    send(sscd_pkg::CMD_GAIN_WR, 8'h01, 8'h2A);
    check("gain_buffered", 6'h00, gainLines);
    send(sscd_pkg::CMD_GAIN_UPD, 8'h01, 8'h00);
    check("gain_updated", 6'h2A, gainLines);
    $display("test buffered updates done");

    send(sscd_pkg::CMD_DIV_WR, 8'h01, 8'h03);
    markCase(8'h02, sscd_pkg::CMD_DIV_UPD, 8'h00, 1'b0);
    send(sscd_pkg::CMD_DIV_WR, 8'h01, 8'h06);
    markCase(8'h42, sscd_pkg::CMD_DIV_UPD, 8'h00, 1'b1);
    send(sscd_pkg::CMD_GAIN_WR, 8'h01, 8'h15);
    markCase(8'h22, sscd_pkg::CMD_GAIN_UPD, 8'h00, 1'b1);
    markCase(8'h12, sscd_pkg::CMD_COMMIT, 8'h00, 1'b1);
    markCase(8'h02, sscd_pkg::CMD_COMMIT, 8'h00, 1'b0);
    markCase(8'h82, sscd_pkg::CMD_FUNC_WR, 8'h09, 1'b1);
    check("func_lines", 8'h09, funcLines);
    markCase(8'h02, sscd_pkg::CMD_FUNC_WR, 8'h0A, 1'b0);
    send(sscd_pkg::CMD_DIV_WR, 8'h01, 8'h01);
    send(sscd_pkg::CMD_GAIN_WR, 8'h01, 8'h3F);
    markCase(8'h72, sscd_pkg::CMD_ALL_UPD, 8'h00, 1'b1);
    check("div_all", 3'h1, dividerLines);
    check("gain_all", 6'h3F, gainLines);
    $display("test update marker done");

    // unmapped host address: the host must still answer and keep working
    apb(1'b0, 8'h0C, 32'h0, scratch);
    for (int k = 0; k < 5; k++) begin
      clr();
      send(linkCmd[k], linkLen[k][7:0], 8'hA5);
      check("sub_select", 32'h1 << k, selSeen);
      check("sub_relay", 1, relaySeen);
      check("sub_reply", {8{subMiso[k]}}, rxByte);
    end
    $display("test pass-through done");
    printVerdict();
  end
endmodule
`default_nettype wire

// ===== logic/sscd_device.sv
// device end: command decoder behind the host serial port
`timescale 1ns/1ps
`default_nettype none
module sscd_device (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  sscd_link_if.device                        link,
  input  wire logic                          pllLock,
  output logic                               aux_monitor_pin,
  output logic                               synth_core_commit_pulse,
  output logic [7:0]                         funcLines,
  output logic [2:0]                         dividerLines,
  output logic [5:0]                         gainLines,
  output logic [sscd_pkg::SUB_COUNT-1:0]     subSelectN,
  output logic                               subSclk,
  output logic                               subMosi,
  input  wire logic [sscd_pkg::SUB_COUNT-1:0] subMiso
);
  logic       selN;
  logic       selRise;
  logic       sclk;
  logic       sclkRise;
  logic       sclkFall;
  logic       mosi;
  logic       lock;
  logic       misoRaw;
  logic [1:0] misoMeta_q;
  logic       lockMeta_q;
  logic       lockSync_q;
  logic [2:0] mosiMeta_q;
  logic       subMisoS;

  sscd_sync_edge uSel (.core_clk(core_clk), .nrst(nrst), .asyncIn(link.hostSelectN),
                       .resetVal(1'b1), .level(selN), .rise(selRise), .fall());
  sscd_sync_edge uClk (.core_clk(core_clk), .nrst(nrst), .asyncIn(link.hostSclk),
                       .resetVal(1'b0), .level(sclk), .rise(sclkRise), .fall(sclkFall));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mosiMeta_q <= 3'h0;
      lockMeta_q <= 1'b0;
      lockSync_q <= 1'b0;
    end else begin
      mosiMeta_q <= {mosiMeta_q[1:0], link.hostMosi};
      lockMeta_q <= pllLock;
      lockSync_q <= lockMeta_q;
    end
  end
  // mosi delayed one more flop so it lines up with the sclk edge flags
  assign mosi = mosiMeta_q[2];
  assign lock = lockSync_q;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  shift_q;
  logic [2:0]  bitCnt_q;
  logic [7:0]  cmd_q;
  logic        haveCmd_q;
  logic [7:0]  dataCnt_q;
  logic [7:0]  txShift_q;
  logic [7:0]  aux_output_select;
  logic [7:0]  divBuf_q;
  logic [7:0]  gainBuf_q;
  logic        marker_q;
  logic        passOn_q;
  logic [2:0]  subIdx_q;
  logic [7:0]  shiftD;
  logic        byteDone;
  logic        isLink;
  logic [2:0]  linkIdx;

  assign shiftD   = {shift_q[6:0], mosi};
  assign byteDone = sclkRise && bitCnt_q == 3'h7 && !selN;

  function automatic logic [3:0] link_of(input logic [7:0] c);
    case (c)
      sscd_pkg::CMD_CORE_LINK:  link_of = {1'b1, 3'(sscd_pkg::SUB_CORE)};
      sscd_pkg::CMD_TEMP_LINK:  link_of = {1'b1, 3'(sscd_pkg::SUB_TEMP)};
      sscd_pkg::CMD_ADC_LINK:   link_of = {1'b1, 3'(sscd_pkg::SUB_ADC)};
      sscd_pkg::CMD_POT_LINK:   link_of = {1'b1, 3'(sscd_pkg::SUB_POT)};
      sscd_pkg::CMD_FLASH_LINK: link_of = {1'b1, 3'(sscd_pkg::SUB_FLASH)};
      default:                  link_of = 4'h0;
    endcase
  endfunction
  wire [3:0] linkSel = link_of(shiftD);
  assign isLink  = linkSel[3];
  assign linkIdx = linkSel[2:0];

  // byte decode on the rising host clock, mode 0
  wire firstData = byteDone && haveCmd_q && dataCnt_q == 8'h00;
  wire wrAux     = firstData && cmd_q == sscd_pkg::CMD_AUX_WR;
  wire wrFunc    = firstData && cmd_q == sscd_pkg::CMD_FUNC_WR;
  wire wrDiv     = firstData && cmd_q == sscd_pkg::CMD_DIV_WR;
  wire wrGain    = firstData && cmd_q == sscd_pkg::CMD_GAIN_WR;
  wire cmdByte   = byteDone && !haveCmd_q;
  // update commands act on the command byte itself; the dummy data byte is ignored
  wire updDiv    = cmdByte && (shiftD == sscd_pkg::CMD_DIV_UPD ||
                               shiftD == sscd_pkg::CMD_ALL_UPD);
  wire updGain   = cmdByte && (shiftD == sscd_pkg::CMD_GAIN_UPD ||
                               shiftD == sscd_pkg::CMD_ALL_UPD);
  wire doCommit  = cmdByte && (shiftD == sscd_pkg::CMD_COMMIT ||
                               shiftD == sscd_pkg::CMD_ALL_UPD);
  wire funcNew   = wrFunc && shiftD != funcLines;
  wire divNew    = updDiv && divBuf_q[2:0] != dividerLines;
  wire gainNew   = updGain && gainBuf_q[5:0] != gainLines;
  wire markSet   = (funcNew && aux_output_select[sscd_pkg::AUX_FUNC_EN])
                || (divNew && aux_output_select[sscd_pkg::AUX_DIV_EN])
                || (gainNew && aux_output_select[sscd_pkg::AUX_GAIN_EN])
                || (doCommit && aux_output_select[sscd_pkg::AUX_COMMIT_EN]);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shift_q   <= 8'h00;
      bitCnt_q  <= 3'h0;
      cmd_q     <= 8'h00;
      haveCmd_q <= 1'b0;
      dataCnt_q <= 8'h00;
      passOn_q  <= 1'b0;
      subIdx_q  <= 3'h0;
    end else if (selN) begin
      bitCnt_q  <= 3'h0;
      haveCmd_q <= 1'b0;
      dataCnt_q <= 8'h00;
      passOn_q  <= 1'b0;
    end else if (sclkRise) begin
      shift_q  <= shiftD;
      bitCnt_q <= bitCnt_q + 3'h1;
      if (byteDone) begin
        if (!haveCmd_q) begin
          cmd_q     <= shiftD;
          haveCmd_q <= 1'b1;
          passOn_q  <= isLink;
          subIdx_q  <= linkIdx;
        end else if (dataCnt_q != 8'hFF) begin
          dataCnt_q <= dataCnt_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aux_output_select       <= sscd_pkg::AUX_RESET;
      funcLines               <= sscd_pkg::REG_RESET;
      divBuf_q                <= sscd_pkg::REG_RESET;
      gainBuf_q               <= sscd_pkg::REG_RESET;
      dividerLines            <= 3'h0;
      gainLines               <= 6'h00;
      synth_core_commit_pulse <= 1'b0;
      marker_q                <= 1'b0;
    end else begin
      if (wrAux)   aux_output_select <= shiftD;
      if (wrFunc)  funcLines <= shiftD;
      if (wrDiv)   divBuf_q <= shiftD;
      if (wrGain)  gainBuf_q <= shiftD;
      if (updDiv)  dividerLines <= divBuf_q[2:0];
      if (updGain) gainLines <= gainBuf_q[5:0];
      synth_core_commit_pulse <= doCommit;
      // set wins over the select-rise clear
      if (markSet)      marker_q <= 1'b1;
      else if (selRise) marker_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply shifts out on falling host clock; read commands load the byte after the command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txShift_q <= 8'h00;
    end else if (byteDone && !haveCmd_q) begin
      case (shiftD)
        sscd_pkg::CMD_AUX_RD: txShift_q <= aux_output_select;
        8'h81:                txShift_q <= {lock, funcLines[6:0]};
        8'h82:                txShift_q <= divBuf_q;
        8'h83:                txShift_q <= gainBuf_q;
        default:              txShift_q <= 8'h00;
      endcase
    end else if (sclkFall && haveCmd_q && !passOn_q) begin
      txShift_q <= {txShift_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      misoMeta_q <= 2'h0;
    end else begin
      misoMeta_q <= {misoMeta_q[0], subMiso[subIdx_q]};
    end
  end
  assign subMisoS = misoMeta_q[1];
  assign misoRaw  = passOn_q ? subMisoS : txShift_q[7];

  wire [1:0] auxSel = aux_output_select[1:0];
  wire auxNext = (auxSel == sscd_pkg::AUX_SRC_LOW)  ? 1'b0 :
                 (auxSel == sscd_pkg::AUX_SRC_LOCK) ? lock :
                 (auxSel == sscd_pkg::AUX_SRC_MARK) ? (marker_q | markSet) : 1'b1;

  generate
    for (genvar i = 0; i < sscd_pkg::SUB_COUNT; i++) begin : gSel
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) subSelectN[i] <= 1'b1;
        else       subSelectN[i] <= !(passOn_q && subIdx_q == 3'(i));
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aux_monitor_pin <= 1'b0;
      subSclk         <= 1'b0;
      subMosi         <= 1'b0;
      link.hostMiso   <= 1'b0;
    end else begin
      aux_monitor_pin <= auxNext;
      subSclk         <= passOn_q & sclk;
      subMosi         <= passOn_q & mosi;
      link.hostMiso   <= misoRaw;
    end
  end
endmodule
`default_nettype wire

// ===== logic/sscd_host.sv
// host end: APB-driven serial command master
`timescale 1ns/1ps
`default_nettype none
module sscd_host (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  sscd_link_if.host        link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // ctrl word: [7:0] command, [15:8] data byte count, [16] go, the one data byte in [31:24]
  // only one data byte is carried per transfer; longer relays repeat bytes of pwdata[31:24]
  logic [7:0] data_q;
  logic [7:0] left_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic [2:0] bitCnt_q;
  logic [3:0] div_q;
  logic       busy_q;
  logic       phase_q;
  logic       misoMeta_q;
  logic       misoSync_q;
  wire access = psel && penable;
  wire halfTick = div_q == sscd_pkg::HALF_DIV - 4'h1;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      misoMeta_q <= 1'b0;
      misoSync_q <= 1'b0;
    end else begin
      misoMeta_q <= link.hostMiso;
      misoSync_q <= misoMeta_q;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_q <= 8'h00; left_q <= 8'h00; rx_q <= 8'h00;
      tx_q <= 8'h00; bitCnt_q <= 3'h0; div_q <= 4'h0; busy_q <= 1'b0;
      phase_q <= 1'b0; link.hostSelectN <= 1'b1; link.hostSclk <= 1'b0;
      link.hostMosi <= 1'b0; prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready  <= access && !pready;
      pslverr <= 1'b0;
      if (access && !pready) begin
        prdata <= (paddr == sscd_pkg::APB_STAT)  ? {31'h0, busy_q} :
                  (paddr == sscd_pkg::APB_RDATA) ? {24'h0, rx_q} : 32'h0;
        if (pwrite && paddr == sscd_pkg::APB_CTRL && pwdata[16] && !busy_q) begin
          data_q <= pwdata[31:24]; left_q <= pwdata[15:8];
          tx_q <= pwdata[7:0]; busy_q <= 1'b1; bitCnt_q <= 3'h0;
          link.hostSelectN <= 1'b0; link.hostMosi <= pwdata[7]; div_q <= 4'h0;
          phase_q <= 1'b0;
        end
      end
      if (busy_q) begin
        div_q <= halfTick ? 4'h0 : div_q + 4'h1;
        if (halfTick) begin
          phase_q <= !phase_q;
          if (!phase_q) begin
            link.hostSclk <= 1'b1;
            rx_q <= {rx_q[6:0], misoSync_q};
          end else begin
            link.hostSclk <= 1'b0;
            bitCnt_q <= bitCnt_q + 3'h1;
            if (bitCnt_q != 3'h7) begin
              link.hostMosi <= tx_q[6];
              tx_q <= {tx_q[6:0], 1'b0};
            end else if (left_q != 8'h00) begin
              left_q <= left_q - 8'h01;
              tx_q <= data_q;
              link.hostMosi <= data_q[7];
            end else begin
              busy_q <= 1'b0;
              link.hostSelectN <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/sscd_link_if.sv
// serial command port between host controller and decoder
`timescale 1ns/1ps
`default_nettype none
interface sscd_link_if;
  logic hostSelectN;
  logic hostSclk;
  logic hostMosi;
  logic hostMiso;
  modport device (input hostSelectN, input hostSclk, input hostMosi, output hostMiso);
  modport host   (output hostSelectN, output hostSclk, output hostMosi, input hostMiso);
endinterface
`default_nettype wire

// ===== logic/sscd_pkg.sv
// shared constants for the synthesizer serial command decoder
package sscd_pkg;
  localparam logic [7:0] CMD_FUNC_WR    = 8'h01;
  localparam logic [7:0] CMD_DIV_WR     = 8'h02;
  localparam logic [7:0] CMD_GAIN_WR    = 8'h03;
  localparam logic [7:0] CMD_AUX_WR     = 8'h05;
  localparam logic [7:0] CMD_AUX_RD     = 8'h85;
  localparam logic [7:0] CMD_CORE_LINK  = 8'h10;
  localparam logic [7:0] CMD_COMMIT     = 8'h11;
  localparam logic [7:0] CMD_DIV_UPD    = 8'h12;
  localparam logic [7:0] CMD_GAIN_UPD   = 8'h13;
  localparam logic [7:0] CMD_ALL_UPD    = 8'h1F;
  localparam logic [7:0] CMD_TEMP_LINK  = 8'h30;
  localparam logic [7:0] CMD_ADC_LINK   = 8'h40;
  localparam logic [7:0] CMD_POT_LINK   = 8'h50;
  localparam logic [7:0] CMD_FLASH_LINK = 8'h70;
  localparam logic [7:0] AUX_RESET      = 8'h00;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam int         AUX_FUNC_EN    = 7;
  localparam int         AUX_DIV_EN     = 6;
  localparam int         AUX_GAIN_EN    = 5;
  localparam int         AUX_COMMIT_EN  = 4;
  localparam logic [1:0] AUX_SRC_LOW    = 2'h0;
  localparam logic [1:0] AUX_SRC_LOCK   = 2'h1;
  localparam logic [1:0] AUX_SRC_MARK   = 2'h2;
  localparam logic [1:0] AUX_SRC_HIGH   = 2'h3;
  localparam int         SUB_CORE       = 0;
  localparam int         SUB_TEMP       = 1;
  localparam int         SUB_ADC        = 2;
  localparam int         SUB_POT        = 3;
  localparam int         SUB_FLASH      = 4;
  localparam int         SUB_COUNT      = 5;
  localparam logic [3:0] HALF_DIV       = 4'h4;
  localparam logic [5:0] CMD_IDLE       = 6'h01;
  localparam logic [5:0] CMD_XFER       = 6'h02;
  localparam logic [5:0] CMD_FINISH     = 6'h04;
  localparam logic [5:0] CMD_DONE       = 6'h08;
  localparam logic [5:0] CMD_APB_SETUP  = 6'h10;
  localparam logic [5:0] CMD_APB_ACCESS = 6'h20;
  localparam logic [7:0] APB_CTRL       = 8'h00;
  localparam logic [7:0] APB_STAT       = 8'h04;
  localparam logic [7:0] APB_RDATA      = 8'h08;
endpackage

// ===== logic/sscd_sync_edge.sv
// two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module sscd_sync_edge (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic asyncIn,
  input  wire logic resetVal,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= asyncIn ^ resetVal;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  // resetVal folds the idle level so reset state reads idle without a port on the async path
  assign level = sync_q ^ resetVal;
  assign rise  = (sync_q ^ resetVal) & ~(prev_q ^ resetVal);
  assign fall  = ~(sync_q ^ resetVal) & (prev_q ^ resetVal);
endmodule
`default_nettype wire
